// ---- tsf_cfg.svh ----
// Constants for the two-stage foot switch initiation block.
//
// Summary of operation
// - First stage closing turns on that input's valves, times pre-squeeze and squeeze, waits.
// - Pedal released while waiting after squeeze turns the valves off.
// - Pedal reaching second stage checks pressure switch, then starts the weld.
// - Early second stage waits for pre-squeeze and squeeze before pressure check and weld.
// - A repeat schedule repeats only while first and second stage are both closed.
// - Single mode: four start inputs are first stages, second stage is input nine.
// - Input nine is second stage only when its function and local source are set.
// - Single mode: any of the four foot switches starts schedule zero.
// - Multiple mode: up to four switches share one second stage, each own schedule.
// - Switch one uses selected or external schedule; switches two to four use 20, 40, 60.
// - Programmable outputs are shared between processor and sequencer by an output map.
// - Start input must stay closed until the valves turn on, else abort.
// - Sequence and valves start on a positive mains half cycle, 0.0 to 16.6 ms later.
`ifndef TSF_CFG_SVH
`define TSF_CFG_SVH
`define TSF_A_CTRL    8'h00
`define TSF_A_SCHED   8'h04
`define TSF_A_VALVE0  8'h08
`define TSF_A_PRESQ   8'h18
`define TSF_A_SQZ     8'h1C
`define TSF_A_IOMAP   8'h20
`define TSF_A_OMAP    8'h24
`define TSF_A_CPUOUT  8'h28
`define TSF_A_STATUS  8'h2C
`define TSF_B_TWO     0
`define TSF_B_MULTI   1
`define TSF_B_REPEAT  2
`define TSF_B_EXTSEL  8
`define TSF_B_FN2ND   0
`define TSF_B_LOCAL   1
`define TSF_SCHED_SW1 7'h00
`define TSF_SCHED_SW2 7'h14
`define TSF_SCHED_SW3 7'h28
`define TSF_SCHED_SW4 7'h3C
`define TSF_CLK_MHZ   100
`define TSF_DEB_US    5000
`define TSF_DEB_CYC   (`TSF_DEB_US * `TSF_CLK_MHZ)
`endif

// ---- tsf_pkg.sv ----
// Types shared by the two-stage foot switch initiation block.
package tsf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARM, ST_PRESQ, ST_SQZ, ST_HOLD, ST_PCHK, ST_WELD, ST_END
  } tsf_state_e;
  typedef struct packed {
    logic       repeat_en;
    logic       multi;
    logic       two_stage;
  } tsf_ctrl_s;
  typedef struct packed {
    logic       src_local;
    logic       fn_second;
  } tsf_iomap_s;
  typedef logic [6:0] tsf_sched_t;
endpackage : tsf_pkg

// ---- tsf_top.sv ----
// Two-stage foot switch start initiation with an AHB-Lite register slave.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_cfg.svh"
module tsf_top #(
  parameter int DEB_CYC = `TSF_DEB_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic [31:0] HRDATA,
  output var  logic        HREADYOUT,
  output var  logic        HRESP,
  input  wire logic [3:0]  START_INITIATION_INPUTS,
  input  wire logic [31:0] PROGRAMMABLE_INPUTS,
  input  wire logic        PRESSURE_SWITCH_INPUT,
  input  wire logic        MAINS_POSITIVE,
  input  wire logic        WELD_DONE,
  output var  logic [7:0]  VALVE_OUTPUTS,
  output var  logic [23:0] PROGRAMMABLE_OUTPUTS,
  output var  logic [6:0]  SCHEDULE_OUT,
  output var  logic        WELD_START,
  output var  logic        SEQ_ACTIVE
);
  // The debounce counter is 24 bits wide, so the limit must fit in it.
  if (DEB_CYC < 1 || DEB_CYC > 2**24 - 1) begin : g_bad_deb
    $error("DEB_CYC out of range");
  end

  localparam int NIN = 6;
  logic [23:0] deb_max;
  assign deb_max = 24'(DEB_CYC);

  // Raw contacts: starts, input nine, pressure switch.
  logic [NIN-1:0] raw_in;
  assign raw_in = {PRESSURE_SWITCH_INPUT, PROGRAMMABLE_INPUTS[8],
                   START_INITIATION_INPUTS};
  // Each debounce lane owns one bit, so every bit has a single driver.
  wire [NIN-1:0] db_q;

  genvar gi;
  for (gi = 0; gi < NIN; gi++) begin : g_deb
    logic        s1_q;
    logic        s2_q;
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic        same;
    logic        db_bit_q;
    assign db_q[gi] = db_bit_q;
    assign same  = (s2_q == db_bit_q);
    assign cnt_d = same ? 24'h00_0000 : cnt_q + 24'h00_0001;
    always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
        s1_q     <= 1'b0;
        s2_q     <= 1'b0;
        cnt_q    <= 24'h00_0000;
        db_bit_q <= 1'b0;
      end else begin
        s1_q  <= raw_in[gi];
        s2_q  <= s1_q;
        cnt_q <= cnt_d;
        if (!same && cnt_d >= deb_max) begin
          db_bit_q <= s2_q;
          cnt_q    <= 24'h00_0000;
        end
      end
    end
  end

  logic m1_q;
  logic m2_q;
  logic m3_q;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      m1_q <= 1'b0;
      m2_q <= 1'b0;
      m3_q <= 1'b0;
    end else begin
      m1_q <= MAINS_POSITIVE;
      m2_q <= m1_q;
      m3_q <= m2_q;
    end
  end
  logic mains_edge;
  assign mains_edge = m2_q & ~m3_q;

  // Register file.
  tsf_pkg::tsf_ctrl_s  ctrl_q;
  tsf_pkg::tsf_iomap_s iomap_q;
  tsf_pkg::tsf_sched_t sel_sched_q;
  logic        ext_sel_q;
  logic [7:0]  valve_map_q [4];
  logic [15:0] presq_q;
  logic [15:0] sqz_q;
  logic [23:0] omap_q;
  logic [23:0] cpu_out_q;

  logic       dp_wr_q;
  logic [7:0] dp_addr_q;
  logic       ap_take;
  assign ap_take = HSEL & HTRANS[1] & HREADY;

  tsf_pkg::tsf_state_e st_q;
  tsf_pkg::tsf_state_e st_d;
  logic [1:0]  idx_q;
  logic [15:0] tmr_q;

  wire [7:0] a_addr = HADDR[7:0];
  wire a_ctrl   = (a_addr == `TSF_A_CTRL);
  wire a_sched  = (a_addr == `TSF_A_SCHED);
  wire a_valve  = (a_addr[7:4] == 4'h0 && a_addr[3]) ||
                  (a_addr[7:4] == 4'h1 && !a_addr[3]);
  wire a_presq  = (a_addr == `TSF_A_PRESQ);
  wire a_sqz    = (a_addr == `TSF_A_SQZ);
  wire a_iomap  = (a_addr == `TSF_A_IOMAP);
  wire a_omap   = (a_addr == `TSF_A_OMAP);
  wire a_cpuout = (a_addr == `TSF_A_CPUOUT);
  wire a_status = (a_addr == `TSF_A_STATUS);
  wire [1:0] a_vidx = 2'(({1'b0, a_addr} - 9'(`TSF_A_VALVE0)) >> 2);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_ctrl) begin
      rd_mux[2:0] = ctrl_q;
    end else if (a_sched) begin
      rd_mux[6:0]          = sel_sched_q;
      rd_mux[`TSF_B_EXTSEL] = ext_sel_q;
    end else if (a_valve) begin
      rd_mux[7:0] = valve_map_q[a_vidx];
    end else if (a_presq) begin
      rd_mux[15:0] = presq_q;
    end else if (a_sqz) begin
      rd_mux[15:0] = sqz_q;
    end else if (a_iomap) begin
      rd_mux[1:0] = iomap_q;
    end else if (a_omap) begin
      rd_mux[23:0] = omap_q;
    end else if (a_cpuout) begin
      rd_mux[23:0] = cpu_out_q;
    end else if (a_status) begin
      rd_mux = {8'h00, db_q, m2_q, idx_q, SCHEDULE_OUT, 5'h00, st_q};
    end
  end

  wire [7:0] d_addr = dp_addr_q;
  wire [1:0] d_vidx = 2'(({1'b0, d_addr} - 9'(`TSF_A_VALVE0)) >> 2);
  wire d_valve = (d_addr[7:4] == 4'h0 && d_addr[3]) ||
                 (d_addr[7:4] == 4'h1 && !d_addr[3]);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      dp_wr_q <= ap_take & HWRITE;
      if (ap_take) begin
        dp_addr_q <= a_addr;
      end
      if (ap_take && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q      <= '0;
      iomap_q     <= '0;
      sel_sched_q <= `TSF_SCHED_SW1;
      ext_sel_q   <= 1'b0;
      presq_q     <= 16'h0000;
      sqz_q       <= 16'h0000;
      omap_q      <= 24'h00_0000;
      cpu_out_q   <= 24'h00_0000;
      for (int i = 0; i < 4; i++) begin
        valve_map_q[i] <= 8'h00;
      end
    end else if (dp_wr_q) begin
      if (d_addr == `TSF_A_CTRL) begin
        ctrl_q <= HWDATA[2:0];
      end else if (d_addr == `TSF_A_SCHED) begin
        sel_sched_q <= HWDATA[6:0];
        ext_sel_q   <= HWDATA[`TSF_B_EXTSEL];
      end else if (d_valve) begin
        valve_map_q[d_vidx] <= HWDATA[7:0];
      end else if (d_addr == `TSF_A_PRESQ) begin
        presq_q <= HWDATA[15:0];
      end else if (d_addr == `TSF_A_SQZ) begin
        sqz_q <= HWDATA[15:0];
      end else if (d_addr == `TSF_A_IOMAP) begin
        iomap_q <= HWDATA[1:0];
      end else if (d_addr == `TSF_A_OMAP) begin
        omap_q <= HWDATA[23:0];
      end else if (d_addr == `TSF_A_CPUOUT) begin
        cpu_out_q <= HWDATA[23:0];
      end
    end
  end

  // Sequencer decisions.
  wire [3:0] start_db = db_q[3:0];
  wire press_ok = db_q[5];
  // Without two-stage wiring the second stage is taken as always closed.
  wire second = ~ctrl_q.two_stage |
                (db_q[4] & iomap_q.fn_second & iomap_q.src_local);
  wire first  = start_db[idx_q];
  wire any_start = |start_db;
  wire [1:0] pick = start_db[0] ? 2'd0 : start_db[1] ? 2'd1 :
                    start_db[2] ? 2'd2 : 2'd3;
  wire [6:0] sw1_sched = ext_sel_q ? PROGRAMMABLE_INPUTS[6:0]
                                   : sel_sched_q;
  tsf_pkg::tsf_sched_t sched_pick;
  assign sched_pick = !ctrl_q.multi ? `TSF_SCHED_SW1 :
                      pick == 2'd0 ? sw1_sched :
                      pick == 2'd1 ? `TSF_SCHED_SW2 :
                      pick == 2'd2 ? `TSF_SCHED_SW3 :
                                     `TSF_SCHED_SW4;
  wire tmr_done = (tmr_q == 16'h0000);

  always_comb begin
    st_d = st_q;
    case (st_q)
      tsf_pkg::ST_IDLE: begin
        if (any_start) st_d = tsf_pkg::ST_ARM;
      end
      tsf_pkg::ST_ARM: begin
        if (!first) st_d = tsf_pkg::ST_IDLE;
        else if (mains_edge) st_d = tsf_pkg::ST_PRESQ;
      end
      tsf_pkg::ST_PRESQ: begin
        if (tmr_done) st_d = tsf_pkg::ST_SQZ;
      end
      tsf_pkg::ST_SQZ: begin
        if (tmr_done) st_d = tsf_pkg::ST_HOLD;
      end
      tsf_pkg::ST_HOLD: begin
        if (!first) st_d = tsf_pkg::ST_IDLE;
        else if (second) st_d = tsf_pkg::ST_PCHK;
      end
      tsf_pkg::ST_PCHK: begin
        if (!first) st_d = tsf_pkg::ST_IDLE;
        else if (press_ok) st_d = tsf_pkg::ST_WELD;
      end
      tsf_pkg::ST_WELD: begin
        if (WELD_DONE) begin
          if (ctrl_q.repeat_en && first && second) st_d = tsf_pkg::ST_PRESQ;
          else st_d = tsf_pkg::ST_END;
        end
      end
      tsf_pkg::ST_END: begin
        if (!first) st_d = tsf_pkg::ST_IDLE;
      end
      default: st_d = tsf_pkg::ST_IDLE;
    endcase
  end

  // The interval timer counts positive mains half cycles.
  logic [15:0] tmr_d;
  assign tmr_d = (st_d == tsf_pkg::ST_PRESQ && st_q != tsf_pkg::ST_PRESQ) ? presq_q :
                 (st_d == tsf_pkg::ST_SQZ && st_q != tsf_pkg::ST_SQZ) ? sqz_q :
                 (mains_edge && !tmr_done) ? tmr_q - 16'h0001 : tmr_q;

  wire valves_on = (st_d != tsf_pkg::ST_IDLE) && (st_d != tsf_pkg::ST_ARM);
  wire [7:0] valve_d = valves_on ? valve_map_q[idx_q] : 8'h00;
  wire seq_on = (st_d == tsf_pkg::ST_WELD);
  wire [23:0] pout_d = (omap_q & {24{seq_on}}) | (~omap_q & cpu_out_q);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st_q                 <= tsf_pkg::ST_IDLE;
      idx_q                <= 2'd0;
      tmr_q                <= 16'h0000;
      VALVE_OUTPUTS        <= 8'h00;
      PROGRAMMABLE_OUTPUTS <= 24'h00_0000;
      SCHEDULE_OUT         <= 7'h00;
      WELD_START           <= 1'b0;
      SEQ_ACTIVE           <= 1'b0;
    end else begin
      st_q                 <= st_d;
      tmr_q                <= tmr_d;
      VALVE_OUTPUTS        <= valve_d;
      PROGRAMMABLE_OUTPUTS <= pout_d;
      SEQ_ACTIVE           <= (st_d != tsf_pkg::ST_IDLE);
      WELD_START           <= seq_on && (st_q != tsf_pkg::ST_WELD);
      if (st_q == tsf_pkg::ST_IDLE && any_start) begin
        idx_q        <= pick;
        SCHEDULE_OUT <= sched_pick;
      end
    end
  end
endmodule : tsf_top
`default_nettype wire

// ---- tsf_pedal.sv ----
// Two-stage foot pedal model: contacts close and open in mechanical order.
`timescale 1ns/1ps
`default_nettype none
module tsf_pedal (
  input  wire logic       clock,
  input  wire logic [1:0] depth,
  input  wire logic [1:0] idx,
  output var  logic [3:0] first_stage,
  output var  logic       second_stage
);
  // Open contacts read low through the input pull-downs.
  always_ff @(posedge clock) begin
    first_stage  <= (depth != 2'h0) ? (4'h1 << idx) : (second_stage ? first_stage : 4'h0);
    second_stage <= (depth == 2'h2) && (first_stage != 4'h0);
  end
endmodule : tsf_pedal
`default_nettype wire

// ---- tsf_checker.sv ----
// Port relations of the foot switch initiation block.
`timescale 1ns/1ps
`default_nettype none
module tsf_checker (
  input wire logic       CLOCK,
  input wire logic       RST_B,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic [3:0] START_INITIATION_INPUTS,
  input wire logic       PRESSURE_SWITCH_INPUT,
  input wire logic       MAINS_POSITIVE,
  input wire logic [7:0] VALVE_OUTPUTS,
  input wire logic       WELD_START,
  input wire logic       SEQ_ACTIVE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready");
  weld_pulse_a: assert property (WELD_START |=> !WELD_START) else $error("long weld pulse");
  idle_valves_a: assert property (!SEQ_ACTIVE |-> VALVE_OUTPUTS == 8'h00)
    else $error("valves on while idle");
  weld_cause_a: assert property (WELD_START |-> PRESSURE_SWITCH_INPUT && |VALVE_OUTPUTS)
    else $error("weld without pressure or valves");
  phase_order_a: assert property ($rose(|VALVE_OUTPUTS) |-> !WELD_START [*4])
    else $error("weld before squeeze");
  release_off_a: assert property ($fell(|VALVE_OUTPUTS) |-> START_INITIATION_INPUTS == 4'h0)
    else $error("valves off while pedal held");
  mains_start_a: assert property ($rose(|VALVE_OUTPUTS) |->
    $past(MAINS_POSITIVE, 2) && !$past(MAINS_POSITIVE, 8)) else $error("valves off mains edge");
  start_held_a: assert property ($rose(|VALVE_OUTPUTS) |-> $past(|START_INITIATION_INPUTS, 8))
    else $error("valves without held start");
  weld_c: cover property (WELD_START);
  valves_on_c: cover property ($rose(|VALVE_OUTPUTS));
  valves_off_c: cover property ($fell(|VALVE_OUTPUTS));
endmodule : tsf_checker
bind tsf_top tsf_checker chk (.CLOCK(CLOCK), .RST_B(RST_B), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .START_INITIATION_INPUTS(START_INITIATION_INPUTS),
  .PRESSURE_SWITCH_INPUT(PRESSURE_SWITCH_INPUT), .MAINS_POSITIVE(MAINS_POSITIVE),
  .VALVE_OUTPUTS(VALVE_OUTPUTS), .WELD_START(WELD_START), .SEQ_ACTIVE(SEQ_ACTIVE));
`default_nettype wire

// ---- tb_two_stage_footswitch_initiation.sv ----
// Self-checking bench for the two-stage foot switch initiation block.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_cfg.svh"
module tb_two_stage_footswitch_initiation;
  logic        clock, rst_b, ht, hw, press, mains, mrun, done, in9, ws, act;
  logic [1:0]  depth, idx;
  logic [3:0]  fs;
  logic [4:0]  mcnt;
  logic [7:0]  ha, valves;
  logic [6:0]  sched, ext;
  logic [23:0] po;
  logic [31:0] hwd, hrd, r;
  logic        hready;
  int          num_errors, tests_run, cyc;
  tsf_pedal PED (.clock(clock), .depth(depth), .idx(idx), .first_stage(fs), .second_stage(in9));
  tsf_top #(.DEB_CYC(4)) DUT (.CLOCK(clock), .RST_B(rst_b), .HSEL(1'b1), .HADDR({24'h0, ha}),
    .HTRANS({ht, 1'b0}), .HWRITE(hw), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(hready),
    .HRDATA(hrd), .HREADYOUT(hready), .HRESP(), .START_INITIATION_INPUTS(fs),
    .PROGRAMMABLE_INPUTS({23'h0, in9, 1'b0, ext}), .PRESSURE_SWITCH_INPUT(press),
    .MAINS_POSITIVE(mains), .WELD_DONE(done), .VALVE_OUTPUTS(valves),
    .PROGRAMMABLE_OUTPUTS(po), .SCHEDULE_OUT(sched), .WELD_START(ws), .SEQ_ACTIVE(act));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    ht <= 1'b1;
    hw <= w;
    ha <= a;
    do @(posedge clock); while (hready !== 1'b1);
    ht <= 1'b0;
    hwd <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrd;
  endtask : bus
  task automatic state_is(input logic [2:0] s);
    bus(1'b0, `TSF_A_STATUS, 32'h0);
    chk("state", 32'(r[2:0]), 32'(s));
  endtask : state_is
  task automatic run_seq(input logic [1:0] i, input logic [6:0] s);
    idx <= i;
    depth <= 2'h2;
    press <= 1'b1;
    for (int n = 0; n < 900 && ws !== 1'b1; n++) tick(1);
    chk("sched", 32'(sched), 32'(s));
    chk("valves", 32'(valves), 32'(8'h01 << i));
    tick(1);
    chk("outmap", 32'(po[1:0]), 32'h3);
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    depth <= 2'h0;
    for (int n = 0; n < 100 && act !== 1'b0; n++) tick(1);
    chk("released", 32'(valves), 32'h0);
    press <= 1'b0;
    tick(2);
  endtask : run_seq
  task automatic t_regs_abort;
    bus(1'b0, 8'h30, 32'h1);
    chk("unmapped", r, 32'h0);
    bus(1'b1, `TSF_A_PRESQ, 32'h2);
    bus(1'b1, `TSF_A_SQZ, 32'h2);
    bus(1'b0, `TSF_A_PRESQ, 32'h0);
    chk("presq", r, 32'h2);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'(`TSF_A_VALVE0 + 4 * i), 32'(8'h01 << i));
    bus(1'b1, `TSF_A_OMAP, 32'h1);
    bus(1'b1, `TSF_A_CPUOUT, 32'h2);
    depth <= 2'h1;
    tick(2);
    depth <= 2'h0;
    tick(20);
    state_is(3'h0);
    mrun <= 1'b0;
    depth <= 2'h1;
    tick(20);
    depth <= 2'h0;
    tick(20);
    mrun <= 1'b1;
    tick(100);
    chk("abort", 32'(valves), 32'h0);
    $display("test regs_abort done");
  endtask : t_regs_abort
  task automatic t_hold;
    bus(1'b1, `TSF_A_CTRL, 32'h1);
    bus(1'b1, `TSF_A_IOMAP, 32'h1);
    depth <= 2'h2;
    tick(300);
    state_is(3'h4);
    chk("hold_on", 32'(valves), 32'h1);
    depth <= 2'h0;
    tick(30);
    chk("hold_rel", 32'(valves), 32'h0);
    state_is(3'h0);
    depth <= 2'h2;
    tick(300);
    bus(1'b1, `TSF_A_IOMAP, 32'h3);
    tick(30);
    state_is(3'h5);
    depth <= 2'h0;
    tick(30);
    chk("hold_off", 32'(valves), 32'h0);
    $display("test hold done");
  endtask : t_hold
  task automatic t_modes;
    logic [6:0] exp_s [4] = '{7'h05, 7'h14, 7'h28, 7'h3C};
    run_seq(2'h2, 7'h00);
    bus(1'b1, `TSF_A_CTRL, 32'h3);
    bus(1'b1, `TSF_A_SCHED, 32'h5);
    for (int i = 0; i < 4; i++) run_seq(2'(i), exp_s[i]);
    ext <= 7'h2A;
    bus(1'b1, `TSF_A_SCHED, 32'h105);
    run_seq(2'h0, 7'h2A);
    $display("test modes done");
  endtask : t_modes
  task automatic t_repeat;
    bus(1'b1, `TSF_A_CTRL, 32'h5);
    idx <= 2'h1;
    depth <= 2'h2;
    press <= 1'b1;
    for (int n = 0; n < 900 && ws !== 1'b1; n++) tick(1);
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(2);
    state_is(3'h2);
    for (int n = 0; n < 900 && ws !== 1'b1; n++) tick(1);
    chk("repeat_weld", 32'(ws), 32'h1);
    depth <= 2'h1;
    tick(20);
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(2);
    state_is(3'h7);
    depth <= 2'h0;
    press <= 1'b0;
    tick(30);
    chk("repeat_off", 32'(valves), 32'h0);
    $display("test repeat done");
  endtask : t_repeat
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cyc <= cyc + 1;
    mcnt <= (mcnt == 5'h13) ? 5'h0 : mcnt + 5'h1;
    if (!mrun) mains <= 1'b0;
    else if (mcnt == 5'h13) mains <= !mains;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    clock = 0;
    forever #5 clock = !clock;
  end
  initial begin
    {rst_b, ht, hw, press, mains, mrun, done, depth, idx, mcnt, ha, hwd, cyc, ext} = '0;
    num_errors = 0;
    tests_run = 0;
    mrun = 1'b1;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    tick(1);
    t_regs_abort();
    t_hold();
    t_modes();
    t_repeat();
    wrap_up();
  end
endmodule : tb_two_stage_footswitch_initiation
`default_nettype wire
